// *** rtl/hce_encoder.sv ***
// hce_encoder.sv: hopping-code packet encoder with Manchester serial output.
// assumes switch and supply-monitor inputs are asynchronous pins; one 50 MHz clock.
`include "hce_params.svh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// cipher: swap this module to change the hopping algorithm
// ----------------------------------------------------------------------------
module hce_cipher #(
  parameter logic [63:0] KEY = `HCE_CIPHER_KEY
) (
  input  wire logic [31:0] plain,
  output logic      [31:0] coded
);
  // eight rotate/add/xor rounds; light mixing, not a strong cipher
  always_comb begin
    logic [31:0] x;
    logic [63:0] k;
    x = plain;
    k = KEY;
    for (int r = 0; r < 8; r++) begin
      x = ({x[26:0], x[31:27]} + k[31:0]) ^ k[63:32];
      k = {k[62:0], k[63]};
    end
    coded = x;
  end
endmodule // hce_cipher

module hce_encoder #(
  parameter int unsigned DEBOUNCE_CYC = `HCE_DEBOUNCE_CYC,
  parameter int unsigned BIT_CYC      = `HCE_BIT_CYC,
  parameter int unsigned GUARD_CYC    = `HCE_GUARD_CYC,
  parameter int          PRE_LEN      = `HCE_PREAMBLE_LEN,
  parameter int          HDR_LEN      = `HCE_HEADER_LEN,
  parameter logic [1:0]  CRC_POLY     = `HCE_CRC_POLY,
  parameter logic [27:0] SERIAL_ID    = `HCE_SERIAL_ID,
  parameter int          FIFO_DEPTH   = `HCE_FIFO_DEPTH
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic button_in_0,
  input  wire logic button_in_1,
  input  wire logic button_in_2,
  input  wire logic button_in_3,
  input  wire logic low_supply_in,
  output logic      rf_serial_out,
  output logic      led_drive_n
);
  import hce_pkg::*;

  localparam int TOTAL = PRE_LEN + HDR_LEN + `HCE_PAYLOAD_LEN;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;

  hce_state_t        state;
  logic [3:0]        btn_meta;
  logic [3:0]        btn;
  logic              low_meta;
  logic              low_sync;
  logic [31:0]       wait_cnt;
  logic [`HCE_CNT_W-1:0] press_cnt;
  logic [TOTAL-1:0]  pkt_shift;
  logic [15:0]       bits_left;
  logic              any_btn;
  logic              wait_done_deb;
  logic              wait_done_grd;
  logic [31:0]       hop_plain;
  logic [31:0]       hop_code;
  logic [64:0]       body;
  logic [1:0]        crc;
  logic [TOTAL-1:0]  packet;
  logic              fifo_in_ready;
  logic              fifo_in_valid;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [0:0]        fifo_out_data;
  logic              ser_busy;
  logic              ser_bit;
  logic [31:0]       ph_cnt;
  logic              ser_last;

  // check field over the 65 body bits, msb first
  function automatic logic [1:0] crc2(input logic [64:0] d, input logic [1:0] poly);
    logic [1:0] c;
    logic       fb;
    c = 2'h0;
    for (int i = 64; i >= 0; i--) begin
      fb = c[1] ^ d[i];
      c  = {c[0], 1'b0} ^ (fb ? poly : 2'h0);
    end
    return c;
  endfunction

  // ----------------------------------------------------------------------------
  // input synchronisers: pins are asynchronous to clk
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      btn_meta <= 4'h0;
      btn      <= 4'h0;
      low_meta <= 1'b0;
      low_sync <= 1'b0;
    end else begin
      btn_meta <= {button_in_3, button_in_2, button_in_1, button_in_0};
      btn      <= btn_meta;
      low_meta <= low_supply_in;
      low_sync <= low_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // packet assembly
  // ----------------------------------------------------------------------------
  assign any_btn       = |btn;
  assign wait_done_deb = (wait_cnt == DEBOUNCE_CYC - 1);
  assign wait_done_grd = (wait_cnt == GUARD_CYC - 1);
  // switch bits and counter ride inside the encrypted word
  assign hop_plain = {btn, SERIAL_ID[11:0], press_cnt};
  // 32 + 28 + 4 + 1 + 2 = 67 payload bits
  assign body   = {hop_code, SERIAL_ID, btn, low_sync};
  assign crc    = crc2(body, CRC_POLY);
  assign packet = {{PRE_LEN{1'b1}}, {HDR_LEN{1'b0}}, body, crc};

  hce_cipher u_cipher (
    .plain (hop_plain),
    .coded (hop_code)
  );

  // ----------------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------------
  assign fifo_in_valid = (state == HCE_SEND);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state     <= HCE_IDLE;
      wait_cnt  <= 32'h0;
      press_cnt <= '0;
      pkt_shift <= '0;
      bits_left <= 16'h0;
    end else begin
      case (state)
        HCE_IDLE: begin
          wait_cnt <= 32'h0;
          if (any_btn) state <= HCE_DEBOUNCE;
        end
        HCE_DEBOUNCE: begin
          wait_cnt <= wait_cnt + 32'h1;
          if (wait_done_deb) begin
            if (any_btn) begin
              state     <= HCE_LOAD;
              press_cnt <= press_cnt + 1'b1;
            end else begin
              state <= HCE_IDLE;
            end
          end
        end
        HCE_LOAD: begin
          pkt_shift <= packet;
          bits_left <= 16'(TOTAL);
          state     <= HCE_SEND;
        end
        HCE_SEND: begin
          // fifo in_ready low stalls the bit feed
          if (fifo_in_ready) begin
            pkt_shift <= {pkt_shift[TOTAL-2:0], 1'b0};
            bits_left <= bits_left - 16'h1;
            if (bits_left == 16'h1) state <= HCE_DRAIN;
          end
        end
        HCE_DRAIN: begin
          wait_cnt <= 32'h0;
          if (!fifo_out_valid && !ser_busy) state <= HCE_GUARD;
        end
        HCE_GUARD: begin
          wait_cnt <= wait_cnt + 32'h1;
          if (wait_done_grd) begin
            wait_cnt <= 32'h0;
            state    <= any_btn ? HCE_LOAD : HCE_IDLE;
          end
        end
        default: state <= HCE_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // bit buffer between assembly and line coder
  // ----------------------------------------------------------------------------
  hce_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (pkt_shift[TOTAL-1]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------------------
  // Manchester line coder
  // ----------------------------------------------------------------------------
  assign ser_last       = ser_busy && (ph_cnt == BIT_CYC - 1);
  // take the next bit on the last cycle so symbols run back to back
  assign fifo_out_ready = !ser_busy || ser_last;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ser_busy      <= 1'b0;
      ser_bit       <= 1'b0;
      ph_cnt        <= 32'h0;
      rf_serial_out <= 1'b0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      ser_busy      <= 1'b1;
      ser_bit       <= fifo_out_data[0];
      ph_cnt        <= 32'h0;
      rf_serial_out <= fifo_out_data[0];
    end else if (ser_last) begin
      ser_busy      <= 1'b0;
      rf_serial_out <= 1'b0;                                        // line rests low
    end else if (ser_busy) begin
      ph_cnt <= ph_cnt + 32'h1;
      if (ph_cnt == HALF_CYC - 1) rf_serial_out <= ~ser_bit;
    end
  end

  // led sinks current during packets and guards
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      led_drive_n <= 1'b1;
    end else begin
      led_drive_n <= (state == HCE_IDLE) || (state == HCE_DEBOUNCE);
    end
  end
endmodule // hce_encoder
`default_nettype wire

// *** rtl/hce_params.svh ***
// hce_params.svh: constants of the hopping-code encoder (lengths, widths, timing counts).
// assumes a single 50 MHz clock; included by bare name from rtl/.
// How it works
// - A pressed switch wakes the encoder, which waits about 6.5 ms and then samples the switches and starts sending.
// - The hopping field is re-encrypted from a counter that steps on every press still held when the debounce wait ends, so each such press sends a new value.
// - Every packet bit leaves on the serial output as a balanced Manchester symbol, high half then low half for a one.
// - A packet goes out as preamble, then sync header, then encrypted and fixed fields, then the check field.
// - The payload after the header is exactly 67 bits long.
// - Each packet is followed by a silent guard period before the next may start.
// - The encrypted part carries the switch bits and counter sync data, and spans 32 bits of hopping value.
// - The low-supply level is sampled for every packet and sent as a flag bit.
// - Packets repeat with guard periods while any switch is held, and the encoder returns to idle on release.
// - Switch inputs are active high and a high input both wakes the encoder and counts as pressed.
// - The led drive sinks current whenever a packet or its guard period is in progress and is released otherwise.
`ifndef HCE_PARAMS_SVH
`define HCE_PARAMS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define HCE_CLK_PERIOD_NS   20
`define HCE_DEBOUNCE_NS     6500000
// least time, rounded up to whole cycles
`define HCE_DEBOUNCE_CYC    ((`HCE_DEBOUNCE_NS + `HCE_CLK_PERIOD_NS - 1) / `HCE_CLK_PERIOD_NS)
`define HCE_BIT_NS          400000
`define HCE_BIT_CYC         (`HCE_BIT_NS / `HCE_CLK_PERIOD_NS)
`define HCE_GUARD_NS        15000000
`define HCE_GUARD_CYC       (`HCE_GUARD_NS / `HCE_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// packet layout
// ----------------------------------------------------------------------------
`define HCE_PREAMBLE_LEN    12
`define HCE_HEADER_LEN      10
`define HCE_PAYLOAD_LEN     67
`define HCE_HOP_W           32
`define HCE_FIXED_W         28
`define HCE_CNT_W           16
`define HCE_CRC_POLY        2'h3
`define HCE_FIFO_DEPTH      16
// arbitrary values, not tied to any product
`define HCE_SERIAL_ID       28'h0a5c3e1
`define HCE_CIPHER_KEY      64'h0123456789abcdef

`endif

// *** rtl/hce_pkg.sv ***
// hce_pkg.sv: types shared by the hopping-code encoder.
// assumes hce_params.svh is on the include path.
package hce_pkg;
  // main sequencer states
  typedef enum logic [2:0] {
    HCE_IDLE,
    HCE_DEBOUNCE,
    HCE_LOAD,
    HCE_SEND,
    HCE_DRAIN,
    HCE_GUARD
  } hce_state_t;
endpackage

// *** rtl/hce_fifo.sv ***
// hce_fifo.sv: small synchronous fifo with valid/ready on both sides.
// assumes one clock, asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module hce_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------------------
  // flags: extra pointer bit tells full from empty
  // ----------------------------------------------------------------------------
  assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // hce_fifo
`default_nettype wire

// *** verification/hce_encoder_props.sv ***
// hce_encoder_props.sv: pin timing checks for the encoder.
// assumes it is bound into hce_encoder with sim-sized counts.
`timescale 1ns/1ps
`default_nettype none
module hce_encoder_props #(
  parameter int unsigned DEBOUNCE_CYC = 20,
  parameter int unsigned BIT_CYC      = 8,
  parameter int unsigned GUARD_CYC    = 30,
  parameter int          PRE_LEN      = 12,
  parameter int          HDR_LEN      = 10
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic button_in_0,
  input wire logic button_in_1,
  input wire logic button_in_2,
  input wire logic button_in_3,
  input wire logic rf_serial_out,
  input wire logic led_drive_n
);
  localparam int HALF   = BIT_CYC / 2;
  localparam int TX_MAX = (PRE_LEN + HDR_LEN + 67) * BIT_CYC + GUARD_CYC + 16;
  wire logic btn_any = button_in_0 | button_in_1 | button_in_2 | button_in_3;
  logic [15:0] hi_run;
  logic [15:0] lo_run;
  logic [15:0] held;
  logic [15:0] free;
  // ------------------------------------------------------------
  // run lengths; saturate so a long idle never wraps
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_run <= '0;
      lo_run <= '1;
      held   <= '0;
      free   <= '0;
    end else begin
      hi_run <= rf_serial_out ? hi_run + 16'(hi_run != '1) : '0;
      lo_run <= !rf_serial_out ? lo_run + 16'(lo_run != '1) : '0;
      held   <= btn_any ? held + 16'(held != '1) : '0;
      free   <= !btn_any ? free + 16'(free != '1) : '0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_reset_quiet: assert property (disable iff (1'b0) reset |-> led_drive_n && !rf_serial_out)
    else $error("outputs active in reset");
  chk_press_debounced: assert property ($fell(led_drive_n) |-> held >= DEBOUNCE_CYC)
    else $error("send started before debounce");
  chk_first_symbol: assert property ($fell(led_drive_n) |-> ##[1:6] rf_serial_out)
    else $error("no preamble one after start");
  chk_tx_inside_led: assert property (rf_serial_out |-> !led_drive_n)
    else $error("line high with led off");
  chk_half_width: assert property ($fell(rf_serial_out) |-> hi_run == HALF || hi_run == 2 * HALF)
    else $error("high run not a whole half symbol");
  chk_guard_silent: assert property ($rose(rf_serial_out) |-> lo_run <= 2 * HALF || lo_run >= GUARD_CYC)
    else $error("packet began inside guard");
  chk_idle_on_release: assert property (free >= TX_MAX |-> led_drive_n)
    else $error("still sending after release");
  chk_stop_on_release: assert property ($rose(led_drive_n) |-> free >= 2)
    else $error("stopped with a button held");
  cover property ($fell(led_drive_n));
  cover property ($rose(led_drive_n));
  cover property ($rose(rf_serial_out) && lo_run >= GUARD_CYC && !led_drive_n);
endmodule // hce_encoder_props
bind hce_encoder hce_encoder_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .BIT_CYC(BIT_CYC), .GUARD_CYC(GUARD_CYC),
  .PRE_LEN(PRE_LEN), .HDR_LEN(HDR_LEN)) u_hce_encoder_props (.clk(clk), .reset(reset),
  .button_in_0(button_in_0), .button_in_1(button_in_1), .button_in_2(button_in_2),
  .button_in_3(button_in_3), .rf_serial_out(rf_serial_out), .led_drive_n(led_drive_n));
`default_nettype wire

// *** verification/hce_rf_receiver.sv ***
// hce_rf_receiver.sv: behavioural data input of the radio module.
// assumes symbols of BIT_CYC cycles and a packet opening with a one.
`timescale 1ns/1ps
`default_nettype none
module hce_rf_receiver #(
  parameter int BIT_CYC = 8,
  parameter int NBITS   = 89
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             rf_serial_out,
  output logic      [NBITS-1:0] bits,
  output logic      [7:0]       pkt_count,
  output logic                  code_err
);
  int   cyc;
  int   idx;
  logic busy;
  logic first;
  // ------------------------------------------------------------
  // slicer: sample mid first half, mid second half
  // ------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      busy      <= 1'b0;
      first     <= 1'b0;
      cyc       <= 0;
      idx       <= 0;
      bits      <= '0;
      pkt_count <= '0;
      code_err  <= 1'b0;
    end else if (!busy) begin
      busy <= rf_serial_out;
      cyc  <= 1;
      idx  <= 0;
    end else begin
      if (cyc == BIT_CYC / 4) first <= rf_serial_out;
      if (cyc == 3 * BIT_CYC / 4) begin
        bits <= {bits[NBITS-2:0], first};
        if (rf_serial_out === first) code_err <= 1'b1;
      end
      // last cycle of a symbol; the packet ends after NBITS symbols
      if (cyc == BIT_CYC - 1) begin
        cyc <= 0;
        idx <= idx + 1;
        if (idx == NBITS - 1) begin
          busy      <= 1'b0;
          pkt_count <= pkt_count + 8'h01;
        end
      end else begin
        cyc <= cyc + 1;
      end
    end
  end
endmodule // hce_rf_receiver
`default_nettype wire

// *** verification/tb_hce_encoder.sv ***
// tb_hce_encoder.sv: self-checking bench for the hopping-code encoder.
// assumes short sim counts; inputs change on the falling edge.
`include "hce_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_hce_encoder;
  localparam int BIT = 8;
  localparam int GRD = 30;
  localparam int TXC = 89 * BIT + GRD + 40;
  logic        clk = 1'b0;
  logic        reset = 1'b0;
  logic [3:0]  btn = 4'h0;
  logic        low_supply_in = 1'b0;
  logic        rf_serial_out;
  logic        led_drive_n;
  logic [88:0] bits;
  logic [7:0]  pkt_count;
  logic        code_err;
  logic [31:0] hop_a;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #10 clk = ~clk;
  hce_encoder #(.DEBOUNCE_CYC(20), .BIT_CYC(BIT), .GUARD_CYC(GRD)) u_hce_encoder (.clk(clk), .reset(reset),
    .button_in_0(btn[0]), .button_in_1(btn[1]), .button_in_2(btn[2]), .button_in_3(btn[3]),
    .low_supply_in(low_supply_in), .rf_serial_out(rf_serial_out), .led_drive_n(led_drive_n));
  hce_rf_receiver #(.BIT_CYC(BIT), .NBITS(89)) u_hce_rf_receiver (.clk(clk), .reset(reset),
    .rf_serial_out(rf_serial_out), .bits(bits), .pkt_count(pkt_count), .code_err(code_err));
  // ------------------------------------------------------------
  // shared checks; hop value is opaque, so only its change is judged
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  function automatic logic [1:0] crc_of(input logic [64:0] d);
    logic [1:0] c;
    c = 2'h0;
    for (int i = 64; i >= 0; i--) c = {c[0], 1'b0} ^ ((d[i] ^ c[1]) ? `HCE_CRC_POLY : 2'h0);
    return c;
  endfunction
  task automatic wait_pkt(input logic [7:0] n);
    for (int i = 0; i < TXC + 60 && pkt_count !== n; i++) @(negedge clk);
    check("packet count", n, pkt_count);
  endtask
  task automatic check_pkt(input logic [3:0] b, input logic lb);
    check("preamble", 32'hfff, bits[88:77]);
    check("header", 32'h0, bits[76:67]);
    check("serial", `HCE_SERIAL_ID, bits[34:7]);
    check("buttons", b, bits[6:3]);
    check("low supply", lb, bits[2]);
    check("crc", crc_of(bits[66:2]), bits[1:0]);
    check("coding", 1'b0, code_err);
    check("led on", 1'b0, led_drive_n);
  endtask
  task automatic release_all();
    btn = 4'h0;
    repeat (TXC) @(negedge clk);
    check("led idle", 1'b1, led_drive_n);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_hold();
    btn = 4'h1;
    wait_pkt(8'h01);
    check_pkt(4'h1, 1'b0);
    hop_a = bits[66:35];
    wait_pkt(8'h02);
    check("repeat hop", hop_a, bits[66:35]);
    release_all();
    check("no extra packet", 8'h02, pkt_count);
  endtask
  task automatic t_repress();
    low_supply_in = 1'b1;
    btn = 4'h1;
    wait_pkt(8'h03);
    check_pkt(4'h1, 1'b1);
    check("hop changed", 1'b1, bits[66:35] !== hop_a);
    release_all();
    low_supply_in = 1'b0;
  endtask
  task automatic t_bounce();
    btn = 4'h6;
    repeat (10) @(negedge clk);
    btn = 4'h0;
    repeat (100) @(negedge clk);
    check("bounce led", 1'b1, led_drive_n);
    check("bounce count", 8'h03, pkt_count);
    btn = 4'ha;
    wait_pkt(8'h04);
    check_pkt(4'ha, 1'b0);
    release_all();
  endtask
  initial begin
    // raised after time zero so the async reset branches see a real edge
    #1 reset = 1'b1;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    t_hold();
    t_repress();
    t_bounce();
    wrap_up();
  end
endmodule // tb_hce_encoder
`default_nettype wire
